// file: acc_defs.svh
// constant definitions for the converter control and comparator block
// assumes inclusion by the top module and the testbench only
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ==========================================
// timing
`define ACC_SYS_CLK_HZ 10000000
`define ACC_OSC_HZ 1000000
`define ACC_MOD_DIV 4
`define ACC_MOD_HZ 250000

// ==========================================
// register byte offsets
`define ACC_OFS_CONFIG 12'h000
`define ACC_OFS_RESULT 12'h004
`define ACC_OFS_UPPER 12'h008
`define ACC_OFS_LOWER 12'h00C
`define ACC_OFS_STATUS 12'h010
`define ACC_OFS_CLEAR 12'h014
`define ACC_OFS_ENABLE 12'h018

// ==========================================
// config field positions
`define ACC_CFG_MUX_LSB 0
`define ACC_CFG_GAIN_LSB 3
`define ACC_CFG_RATE_LSB 6
`define ACC_CFG_WIN_BIT 9
`define ACC_CFG_POL_BIT 10
`define ACC_CFG_LAT_BIT 11
`define ACC_CFG_QUE_LSB 12

// ==========================================
// reset values
`define ACC_RST_CONFIG 14'h3110
`define ACC_RST_UPPER 16'h7FFF
`define ACC_RST_LOWER 16'h8000
`define ACC_QUE_OFF 2'h3
`define ACC_FIXED_GAIN 3'h2

// ==========================================
// status bits
`define ACC_ST_DONE 0
`define ACC_ST_ALERT 1
`define ACC_ST_W 2

`endif

// file: acc_pkg.sv
// types shared by the converter control and comparator block
// assumes acc_defs.svh is on the include path
package acc_pkg;
  typedef struct packed {
    logic [1:0] cmp_queue_cnt;
    logic cmp_latch_en;
    logic cmp_polarity;
    logic cmp_window_sel;
    logic [2:0] rate_select;
    logic [2:0] gain_range_sel;
    logic [2:0] input_select;
  } acc_config_t;

  typedef struct packed {
    logic [1:0] pos_sel;
    logic [1:0] neg_sel;
    logic neg_to_gnd;
  } acc_route_t;
endpackage

// file: acc_top.sv
// converter control: apb registers, mux routing, range, rate timing and alert comparator
// assumes a 10 MHz clock, synchronous inputs, results arriving as one-cycle strobes
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "acc_defs.svh"

// Notes on behaviour
// - input_select routes four single-ended, two differential, and inputs 0,1 against 3.
// - single-ended selections switch the negative converter input to ground.
// - modulator clock is the 1 MHz oscillator divided by four, 250 kHz.
// - gain_range_sel picks full-scale range from 6.144 V down to 0.256 V.
// - code step weight is full-scale range divided by two to the fifteenth.
// - rate_select chooses 8, 16, 32, 64, 128, 250, 475 or 860 samples per second.
// - conversion time equals one output period, the reciprocal of data rate.
// - runs only from internal oscillator; data rate scales with its frequency.
// - cmp_window_sel chooses traditional or window comparator behaviour.
// - traditional: assert above upper limit, release only below lower limit.
// - window: assert while result is above upper or below lower limit.
// - alert active low by default; cmp_polarity makes it active high.
// - latched alert holds until alert response or conversion result read.
// - cmp_queue_cnt demands one, two or four successive beyond-limit results.
// - a disable setting turns comparator off and holds alert pin high.
// - queue code 11b is disable; other codes keep the alert enabled.
// - alert pin is open drain: drives low only, otherwise released.
module acc_top #(
  parameter bit HAS_GAIN_AMP = 1'b1,
  parameter int OSC_DIV = `ACC_SYS_CLK_HZ / `ACC_OSC_HZ
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic result_valid_i,
  input wire logic [15:0] result_data_i,
  input wire logic alert_response_i,
  output acc_pkg::acc_route_t route_o,
  output logic [2:0] fsr_code_o,
  output logic [27:0] lsb_weight_pv_o,
  output logic mod_tick_o,
  output logic conv_start_o,
  output logic alert_ready_pin_o,
  output logic alert_ready_pin_oe_o,
  output logic irq_o
);

  // ==========================================
  // helper functions
  function automatic logic [14:0] period_ticks(input logic [2:0] rate);
    int sps;
    case (rate)
      3'h0: sps = 8;
      3'h1: sps = 16;
      3'h2: sps = 32;
      3'h3: sps = 64;
      3'h4: sps = 128;
      3'h5: sps = 250;
      3'h6: sps = 475;
      default: sps = 860;
    endcase
    return 15'(`ACC_MOD_HZ / sps);
  endfunction

  function automatic logic [2:0] eff_gain(input logic [2:0] sel);
    return HAS_GAIN_AMP ? sel : `ACC_FIXED_GAIN;
  endfunction

  // weight in picovolts; codes above the narrowest range repeat it
  function automatic logic [27:0] lsb_pv(input logic [2:0] g);
    logic [27:0] w;
    w = 28'h0773594;
    case (g)
      3'h0: w = 28'hB2D05E0;
      3'h1: w = 28'h7735940;
      3'h2: w = 28'h3B9ACA0;
      3'h3: w = 28'h1DCD650;
      3'h4: w = 28'h0EE6B28;
      default: w = 28'h0773594;
    endcase
    return w;
  endfunction

  function automatic acc_pkg::acc_route_t route_of(input logic [2:0] sel);
    acc_pkg::acc_route_t r;
    r = '0;
    case (sel)
      3'h0: begin
        r.pos_sel = 2'h0;
        r.neg_sel = 2'h1;
        r.neg_to_gnd = 1'b0;
      end
      3'h1: begin
        r.pos_sel = 2'h0;
        r.neg_sel = 2'h3;
        r.neg_to_gnd = 1'b0;
      end
      3'h2: begin
        r.pos_sel = 2'h1;
        r.neg_sel = 2'h3;
        r.neg_to_gnd = 1'b0;
      end
      3'h3: begin
        r.pos_sel = 2'h2;
        r.neg_sel = 2'h3;
        r.neg_to_gnd = 1'b0;
      end
      default: begin
        r.pos_sel = sel[1:0];
        r.neg_sel = 2'h0;
        r.neg_to_gnd = 1'b1;
      end
    endcase
    return r;
  endfunction

  // ==========================================
  // registers
  acc_pkg::acc_config_t cfg;
  logic [15:0] upper_limit_reg;
  logic [15:0] lower_limit_reg;
  logic [15:0] result_reg;
  logic [`ACC_ST_W-1:0] status;
  logic [`ACC_ST_W-1:0] irq_en;
  logic [31:0] next_rdata;
  logic addr_ok;
  logic access;
  logic done_wr;
  logic done_rd;

  assign access = psel_i && penable_i;
  assign done_wr = access && pready_o && pwrite_i && !pslverr_o;
  assign done_rd = access && pready_o && !pwrite_i && !pslverr_o;

  always_comb begin
    addr_ok = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      `ACC_OFS_CONFIG: next_rdata = {18'h0, cfg};
      `ACC_OFS_RESULT: next_rdata = {16'h0, result_reg};
      `ACC_OFS_UPPER: next_rdata = {16'h0, upper_limit_reg};
      `ACC_OFS_LOWER: next_rdata = {16'h0, lower_limit_reg};
      `ACC_OFS_STATUS: next_rdata = {30'h0, status};
      `ACC_OFS_CLEAR: next_rdata = 32'h0000_0000;
      `ACC_OFS_ENABLE: next_rdata = {30'h0, irq_en};
      default: addr_ok = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (access && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= !addr_ok;
      prdata_o <= (pwrite_i || !addr_ok) ? 32'h0000_0000 : next_rdata;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg <= `ACC_RST_CONFIG;
      upper_limit_reg <= `ACC_RST_UPPER;
      lower_limit_reg <= `ACC_RST_LOWER;
      irq_en <= 2'h0;
    end else if (done_wr) begin
      case (paddr_i)
        `ACC_OFS_CONFIG: cfg <= pwdata_i[13:0];
        `ACC_OFS_UPPER: upper_limit_reg <= pwdata_i[15:0];
        `ACC_OFS_LOWER: lower_limit_reg <= pwdata_i[15:0];
        `ACC_OFS_ENABLE: irq_en <= pwdata_i[`ACC_ST_W-1:0];
        default: irq_en <= irq_en;
      endcase
    end
  end

  // ==========================================
  // oscillator and modulator clock enables
  logic [7:0] osc_cnt;
  logic osc_tick;
  logic [1:0] mod_cnt;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (osc_cnt == 8'(OSC_DIV - 1));
      osc_cnt <= (osc_cnt == 8'(OSC_DIV - 1)) ? 8'h00 : osc_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mod_cnt <= 2'h0;
      mod_tick_o <= 1'b0;
    end else begin
      mod_tick_o <= osc_tick && (mod_cnt == 2'(`ACC_MOD_DIV - 1));
      if (osc_tick) begin
        mod_cnt <= mod_cnt + 2'h1;
      end
    end
  end

  // ==========================================
  // conversion timing: rate_select takes effect at the next period start
  logic [14:0] conv_cnt;
  logic [14:0] conv_len;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      conv_cnt <= 15'h0000;
      conv_len <= period_ticks(3'h4);
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      if (mod_tick_o) begin
        if (conv_cnt + 15'h0001 >= conv_len) begin
          conv_cnt <= 15'h0000;
          conv_len <= period_ticks(cfg.rate_select);
          conv_start_o <= 1'b1;
        end else begin
          conv_cnt <= conv_cnt + 15'h0001;
        end
      end
    end
  end

  // ==========================================
  // routing and range outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      route_o <= route_of(3'h0);
    end else begin
      route_o <= route_of(cfg.input_select);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fsr_code_o <= `ACC_FIXED_GAIN;
    end else begin
      fsr_code_o <= eff_gain(cfg.gain_range_sel);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lsb_weight_pv_o <= lsb_pv(`ACC_FIXED_GAIN);
    end else begin
      lsb_weight_pv_o <= lsb_pv(eff_gain(cfg.gain_range_sel));
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_reg <= 16'h0000;
    end else if (result_valid_i) begin
      result_reg <= result_data_i;
    end
  end

  // ==========================================
  // comparator
  logic above;
  logic below;
  logic beyond;
  logic [2:0] queue_cnt;
  logic [2:0] queue_need;
  logic alert_act;
  logic next_alert;
  logic cmp_off;
  logic rd_result;
  logic alert_set;

  assign above = $signed(result_data_i) > $signed(upper_limit_reg);
  assign below = $signed(result_data_i) < $signed(lower_limit_reg);
  assign beyond = cfg.cmp_window_sel ? (above || below) : above;
  assign cmp_off = (cfg.cmp_queue_cnt == `ACC_QUE_OFF);
  assign queue_need = 3'h1 << cfg.cmp_queue_cnt;
  assign rd_result = done_rd && (paddr_i == `ACC_OFS_RESULT);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || cmp_off) begin
      queue_cnt <= 3'h0;
    end else if (result_valid_i) begin
      if (!beyond) begin
        queue_cnt <= 3'h0;
      end else if (queue_cnt < queue_need) begin
        queue_cnt <= queue_cnt + 3'h1;
      end
    end
  end

  // queue need wraps to zero at the disable code, so gate on cmp_off
  assign alert_set = !cmp_off && result_valid_i && beyond && (queue_cnt + 3'h1 >= queue_need);

  always_comb begin
    next_alert = alert_act;
    if (cfg.cmp_latch_en) begin
      if (rd_result || alert_response_i) begin
        next_alert = 1'b0;
      end
    end else if (result_valid_i) begin
      if (cfg.cmp_window_sel) begin
        next_alert = next_alert && beyond;
      end else if (below) begin
        next_alert = 1'b0;
      end
    end
    if (alert_set) begin
      next_alert = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || cmp_off) begin
      alert_act <= 1'b0;
    end else begin
      alert_act <= next_alert;
    end
  end

  // open drain pin: level is always low, only the enable moves
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      alert_ready_pin_o <= 1'b0;
    end else begin
      alert_ready_pin_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      alert_ready_pin_oe_o <= 1'b0;
    end else if (cmp_off) begin
      alert_ready_pin_oe_o <= 1'b0;
    end else begin
      alert_ready_pin_oe_o <= cfg.cmp_polarity ? !next_alert : next_alert;
    end
  end

  // ==========================================
  // interrupts: sticky status, write one to clear, set wins
  logic [`ACC_ST_W-1:0] ev;
  logic [`ACC_ST_W-1:0] clr;
  logic [`ACC_ST_W-1:0] next_status;

  assign ev = {next_alert && !alert_act, result_valid_i};
  assign clr = (done_wr && paddr_i == `ACC_OFS_CLEAR) ? pwdata_i[`ACC_ST_W-1:0] : 2'h0;
  assign next_status = (status & ~clr) | ev;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status <= 2'h0;
    end else begin
      status <= next_status;
    end
  end

  // irq follows the status it will hold, so it rises with the event
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & irq_en);
    end
  end

endmodule  // acc_top

// file: acc_conv_model.sv
// result source standing in for the conversion core
// assumes strobe requests change right after a rising edge
`timescale 1ns/1ps
module acc_conv_model (
  input logic sys_clk_i,
  input logic go_i,
  input logic [15:0] val_i,
  output logic result_valid_o,
  output logic [15:0] result_data_o
);
  logic [15:0] last = 16'hA5A5;
  always @(posedge sys_clk_i) if (go_i) last <= val_i;
  assign result_valid_o = go_i;
  // data is junk outside a strobe
  assign result_data_o = go_i ? val_i : ~last;
endmodule // acc_conv_model

// file: acc_top_asserts.sv
// port assertions for acc_top
// assumes one clock domain and the synchronous reset of acc_top
`timescale 1ns/1ps
module acc_chk #(
  parameter int OSC_DIV = 10
) (
  input logic sys_clk_i,
  input logic rst_i,
  input logic psel_i,
  input logic penable_i,
  input logic pready_o,
  input logic pslverr_o,
  input logic result_valid_i,
  input logic alert_response_i,
  input acc_pkg::acc_route_t route_o,
  input logic [2:0] fsr_code_o,
  input logic [27:0] lsb_weight_pv_o,
  input logic mod_tick_o,
  input logic alert_ready_pin_o,
  input logic alert_ready_pin_oe_o
);
  localparam int TICK = OSC_DIV * 4;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // apb
  property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("stray error");
  // ==========
  // converter
  property p_tick; mod_tick_o |-> ##[TICK:TICK] mod_tick_o; endproperty
  a_tick: assert property (p_tick) else $error("tick period");
  property p_pin; !alert_ready_pin_o; endproperty
  a_pin: assert property (p_pin) else $error("pin driven high");
  property p_oe;
    $changed(alert_ready_pin_oe_o) |->
      $past(result_valid_i) || $past(alert_response_i) || $past(psel_i) || $past(psel_i, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("alert moved");
  property p_route;
    route_o.neg_to_gnd ? route_o.neg_sel == 2'h0 : route_o.neg_sel > route_o.pos_sel;
  endproperty
  a_route: assert property (p_route) else $error("bad route");
  property p_lsb;
    lsb_weight_pv_o == (fsr_code_o == 3'h0 ? 28'hB2D05E0 : fsr_code_o == 3'h1 ? 28'h7735940
      : fsr_code_o > 3'h4 ? 28'h0773594 : 28'h3B9ACA0 >> (fsr_code_o - 3'h2));
  endproperty
  a_lsb: assert property (p_lsb) else $error("bad lsb");
endmodule // acc_chk

bind acc_top acc_chk #(.OSC_DIV(OSC_DIV)) u_acc_chk (.sys_clk_i, .rst_i, .psel_i,
  .penable_i, .pready_o, .pslverr_o, .result_valid_i, .alert_response_i, .route_o,
  .fsr_code_o, .lsb_weight_pv_o, .mod_tick_o, .alert_ready_pin_o, .alert_ready_pin_oe_o);

// file: testbench.sv
// self-checking bench for acc_top with a result source model
// assumes the package, design, model and checker are compiled first
`timescale 1ns/1ps
`include "acc_defs.svh"
module testbench;
  localparam int DIV = 2;
  localparam logic [11:0] CFG = `ACC_OFS_CONFIG;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, resp = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rdat;
  logic [15:0] val = 16'h0000, rd;
  logic prdy, perr_o, perr, rv, cst, oe, irq;
  acc_pkg::acc_route_t route;
  logic [2:0] fsr;
  int miscompares = 0, checked = 0;
  always #50 clk = ~clk;
  acc_conv_model u_acc_conv_model (.sys_clk_i(clk), .go_i(go), .val_i(val),
    .result_valid_o(rv), .result_data_o(rd));
  acc_top #(.OSC_DIV(DIV)) u_acc_top (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr_o), .result_valid_i(rv), .result_data_i(rd),
    .alert_response_i(resp), .route_o(route), .fsr_code_o(fsr), .lsb_weight_pv_o(),
    .mod_tick_o(), .conv_start_o(cst), .alert_ready_pin_o(), .alert_ready_pin_oe_o(oe),
    .irq_o(irq));
  // ==========
  // shared tasks
  task automatic wrap_up;
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rdat = prd;
    perr = perr_o;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      wrap_up();
    end
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] q, input logic [2:0] lpw, m);
    return {18'h00000, q, lpw, 3'h7, 3'h2, m};
  endfunction
  task automatic res(input logic [15:0] v, input logic e);
    @(posedge clk);
    go <= 1'b1;
    val <= v;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    chk(32'(oe), 32'(e));
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    apb(1'b0, CFG, 32'h0);
    chk(rdat, 32'h00003110);
    @(negedge clk);
    chk(32'({oe, irq, route, fsr}), 32'h00000012);
    apb(1'b0, `ACC_OFS_LOWER, 32'h0);
    chk(32'(rdat[15:0]), 32'h00008000);
    apb(1'b0, 12'h01C, 32'h0);
    chk({rdat[30:0], perr}, 32'h00000001);
  endtask
  task automatic t_mux;
    logic [31:0] c;
    for (int i = 0; i < 8; i++) begin
      c = cfg(2'h3, 3'h0, i[2:0]);
      c[5:3] = i[2:0];
      apb(1'b1, CFG, c);
      repeat (2) @(negedge clk);
      chk(32'(route), i > 3 ? {i[1:0], 3'h1} : i == 0 ? 32'h2 : {i[1:0] - 2'h1, 3'h6});
      chk(32'(fsr), 32'(i));
    end
  endtask
  task automatic t_cmp;
    apb(1'b1, `ACC_OFS_UPPER, 32'h00000064);
    apb(1'b1, `ACC_OFS_LOWER, 32'h0000FF9C);
    apb(1'b1, CFG, cfg(2'h0, 3'h0, 3'h0));
    res(16'h00C8, 1'b1);
    res(16'h0032, 1'b1);
    res(16'hFF38, 1'b0);
    apb(1'b1, CFG, cfg(2'h0, 3'h1, 3'h0));
    res(16'hFF38, 1'b1);
    res(16'h0032, 1'b0);
    apb(1'b1, CFG, cfg(2'h0, 3'h3, 3'h0));
    res(16'h0032, 1'b1);
    res(16'h00C8, 1'b0);
  endtask
  task automatic t_queue;
    for (int q = 0; q < 4; q++) begin
      apb(1'b1, CFG, cfg(q[1:0], 3'h1, 3'h0));
      res(16'h0032, 1'b0);
      repeat ((q == 3 ? 4 : 1 << q) - 1) res(16'h00C8, 1'b0);
      res(16'h00C8, q != 3);
    end
  endtask
  task automatic t_latch;
    apb(1'b1, CFG, cfg(2'h0, 3'h5, 3'h0));
    res(16'h00C8, 1'b1);
    res(16'h0032, 1'b1);
    apb(1'b0, `ACC_OFS_RESULT, 32'h0);
    chk(32'(rdat[15:0]), 32'h00000032);
    repeat (2) @(negedge clk);
    chk(32'(oe), 32'h0);
    res(16'h00C8, 1'b1);
    @(posedge clk);
    resp <= 1'b1;
    @(posedge clk);
    resp <= 1'b0;
    @(negedge clk);
    chk(32'(oe), 32'h0);
  endtask
  task automatic t_irq;
    apb(1'b0, `ACC_OFS_STATUS, 32'h0);
    chk(32'(rdat[1:0]), 32'h3);
    apb(1'b1, `ACC_OFS_ENABLE, 32'h1);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, `ACC_OFS_ENABLE, 32'h0);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, `ACC_OFS_CLEAR, 32'h3);
    apb(1'b1, `ACC_OFS_ENABLE, 32'h3);
    apb(1'b0, `ACC_OFS_STATUS, 32'h0);
    chk(32'({irq, rdat[1:0]}), 32'h0);
  endtask
  task automatic t_rate;
    int n;
    int sps[3] = '{250, 475, 860};
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, CFG, (cfg(2'h3, 3'h0, 3'h0) & ~32'h000001C0) | (32'(r + 5) << 6));
      for (int k = 0; k < 3; k++) begin
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (cst !== 1'b1 && n < 20000);
        if (n >= 20000) begin
          miscompares++;
          wrap_up();
        end
      end
      chk(32'(n), 32'(`ACC_MOD_HZ / sps[r] * `ACC_MOD_DIV * DIV));
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mux();
    t_cmp();
    t_queue();
    t_latch();
    t_irq();
    t_rate();
    wrap_up();
  end
endmodule // testbench
